//--- core/foc_pkg.sv
// Purpose: Shared constants of the front-end configuration and output coder
// Assumes: Sixteen-bit serial words, address in bits 2:0, sent LSB first
// Notes: Field positions are bit indices within a register word
package foc_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 3;
  localparam int CODE_W = 10;
  localparam int SAMP_CNT_W = 4;

  // Bits per write and the saturating count one past it
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] WORD_OVER = 5'h11;

  // Register addresses
  localparam logic [2:0] ADDR_GAIN = 3'h0;
  localparam logic [2:0] ADDR_POWER = 3'h1;
  localparam logic [2:0] ADDR_CLAMP = 3'h2;
  localparam logic [2:0] ADDR_OUTPUT = 3'h3;
  localparam logic [2:0] ADDR_LAST = 3'h3;

  // gain_input_config fields
  localparam int GAIN_LSB = 5;
  localparam int GAIN_W = 8;
  localparam int PATH_BIT = 15;

  // power_filter_config fields
  localparam int SLEEP_BIT = 3;
  localparam int HOLD_BIT = 4;
  localparam int TEST_A_BIT = 5;
  localparam int TEST_B_BIT = 6;
  localparam int TEST_C_BIT = 7;
  localparam int SHA_LSB = 8;
  localparam int SHA_W = 2;
  localparam int TC_LSB = 10;
  localparam int TC_W = 4;

  // clamp_control_config fields
  localparam int CLAMP_LSB = 3;
  localparam int CLAMP_W = 5;
  localparam int STOP_LSB = 8;
  localparam int MULT_LSB = 10;
  localparam int LEADIN_W = 2;
  localparam int SPEED_BIT = 12;
  localparam int POL_BIT = 13;
  localparam int SRST_BIT = 15;
  localparam logic [9:0] CLAMP_OFFSET = 10'h00E;

  // output_code_config fields
  localparam int CBIAS_BIT = 3;
  localparam int FMT_LSB = 4;
  localparam int FMT_W = 2;
  localparam int AVG_BIT = 6;
  localparam int REFT_LSB = 7;
  localparam int REFT_W = 2;
  localparam int EDGE_BIT = 9;
  localparam logic [3:0] REF_FIRST_POS = 4'h3;

  // Reset values: clamp field 9, soft reset released, timing inputs as received
  localparam logic [15:0] RST_GAIN = 16'h0000;
  localparam logic [15:0] RST_POWER = 16'h0000;
  localparam logic [15:0] RST_CLAMP = 16'hA048;
  localparam logic [15:0] RST_OUTPUT = 16'h0000;

  // Output encodings
  typedef enum logic [1:0] {
    FOC_FMT_BIN = 2'h0,
    FOC_FMT_GRAY = 2'h1,
    FOC_FMT_DBIN = 2'h2,
    FOC_FMT_DGRAY = 2'h3
  } foc_fmt_t;

endpackage : foc_pkg

//--- core/foc_coder.sv
// Purpose: Converter output encoder: binary, Gray, and differential forms
// Assumes: One code per code_valid pulse on the system clock
// Notes: Reference samples always go out absolute so the receiver can rebuild codes
`timescale 1ns/1ps
module foc_coder #(
  parameter int CW = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [1:0] fmt,
  input wire logic is_ref,
  input wire logic code_valid,
  input wire logic [CW-1:0] code_in,
  output logic [CW-1:0] code_out,
  output logic code_out_valid,
  output logic code_out_ref
);

  typedef struct packed {
    logic [CW-1:0] prev;
    logic [CW-1:0] dout;
    logic vld;
    logic rf;
  } foc_cst_t;

  foc_cst_t r;
  foc_cst_t n;

  function automatic logic [CW-1:0] to_gray(input logic [CW-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  always_comb begin
    logic [CW-1:0] diff;
    diff = '0;
    n = r;
    n.vld = 1'b0;
    if (!enable) begin
      n.prev = '0;
      n.dout = '0;
      n.rf = 1'b0;
    end else if (code_valid) begin
      diff = code_in - r.prev;
      n.prev = code_in;
      n.vld = 1'b1;
      n.rf = is_ref;
      case (foc_pkg::foc_fmt_t'(fmt))
        foc_pkg::FOC_FMT_BIN: n.dout = code_in;
        foc_pkg::FOC_FMT_GRAY: n.dout = to_gray(code_in);
        foc_pkg::FOC_FMT_DBIN: n.dout = is_ref ? code_in : diff;
        foc_pkg::FOC_FMT_DGRAY: n.dout = is_ref ? to_gray(code_in) : to_gray(diff);
        default: n.dout = code_in;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign code_out = r.dout;
  assign code_out_valid = r.vld;
  assign code_out_ref = r.rf;

endmodule : foc_coder

//--- core/foc_frontend_cfg.sv
// Purpose: Serial-written configuration registers and output coding of a camera front-end
// Assumes: Serial pins and timing pins are asynchronous; serial clock well below system clock
// Notes: Registers are write only; the decoded fields leave as registered outputs
//
// Behaviour
// - Register 0 bits 12:5 hold the eight-bit amplifier gain code.
// - Register 0 bit 15 picks direct converter input, else double-sampling input.
// - Register 1 bit 3 stops the coder and lead-in; host recalibrates offset after waking.
// - Register 1 bits 9:8 select the sample amplifier low-pass setting.
// - Register 1 bits 13:10 set the black-level sampling time constant.
// - Register 2 bits 7:3 give black target code twice field plus 14.
// - Register 2 bits 11:8 set fast lead-in; gain step of one starts it unless stopped or in soft reset.
// - Register 2 bit 12 selects 36 MHz grade at 0, 25 MHz at 1.
// - Register 2 bit 13 keeps timing inputs at 1, inverts them at 0.
// - Register 2 bit 15 low holds soft reset; host recalibrates after.
// - Register 3 bit 3 switches centre bias off in direct input mode.
// - Register 3 bit 6 averages clamp detection over four lines.
// - Register 3 bits 5:4 choose binary, Gray, or differential encodings.
// - Output timing field places reference data at positions three through seven.
// - Register 3 bit 9 picks converter clock edge against black pulse.
// - Serial data is sampled on each serial clock rising edge while chip select is low.
// - A write cut short before sixteen bits changes no register.
`timescale 1ns/1ps
module foc_frontend_cfg #(
  parameter int CW = foc_pkg::CODE_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic serial_cs_n,
  input wire logic serial_write_line,
  input wire logic sample_pulse_input,
  input wire logic sample_blank_input,
  input wire logic pre_blank_input,
  input wire logic optical_black_pulse,
  input wire logic code_valid,
  input wire logic [CW-1:0] code_in,
  output logic [7:0] pga_gain_code,
  output logic input_path_select,
  output logic full_power_down,
  output logic reference_only_hold,
  output logic [1:0] sha_filter_select,
  output logic [3:0] black_sample_tc_select,
  output logic [9:0] clamp_target_code,
  output logic [1:0] fast_leadin_stop_select,
  output logic [1:0] fast_leadin_gain_mult,
  output logic fast_leadin_start,
  output logic speed_grade_select,
  output logic sample_pulse_out,
  output logic sample_blank_out,
  output logic pre_blank_out,
  output logic soft_reset_active,
  output logic centre_bias_off,
  output logic clamp_multi_line_average,
  output logic converter_clock_edge,
  output logic [CW-1:0] code_out,
  output logic code_out_valid,
  output logic code_out_ref
);

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] sd_s;
    logic [2:0] sp_s;
    logic [2:0] sb_s;
    logic [2:0] pb_s;
    logic [2:0] ob_s;
    logic [15:0] shift;
    logic [4:0] nbits;
    logic [15:0] reg_gain;
    logic [15:0] reg_power;
    logic [15:0] reg_clamp;
    logic [15:0] reg_output;
    logic [3:0] samp_pos;
    logic leadin;
    logic sp_o;
    logic sb_o;
    logic pb_o;
    logic [9:0] clamp_code;
    logic cbias;
  } foc_st_t;

  foc_st_t r;
  foc_st_t n;

  logic sck_rise;
  logic cs_start;
  logic cs_end;
  logic obp_rise;
  logic coder_en;
  logic is_ref;
  logic [3:0] ref_pos;
  logic [7:0] new_gain;
  logic [7:0] old_gain;
  logic [1:0] ref_sel;

  function automatic logic step_of_one(input logic [7:0] a, input logic [7:0] b);
    step_of_one = ((a - b) == 8'h01) || ((b - a) == 8'h01);
  endfunction : step_of_one

  // Edges are taken from the second and third stages only
  assign sck_rise = r.sck_s[1] & ~r.sck_s[2];
  assign cs_start = ~r.cs_s[1] & r.cs_s[2];
  assign cs_end = r.cs_s[1] & ~r.cs_s[2];
  assign obp_rise = r.ob_s[1] & ~r.ob_s[2];

  assign new_gain = r.shift[foc_pkg::GAIN_LSB +: foc_pkg::GAIN_W];
  assign old_gain = r.reg_gain[foc_pkg::GAIN_LSB +: foc_pkg::GAIN_W];
  assign ref_sel = r.reg_output[foc_pkg::REFT_LSB +: foc_pkg::REFT_W];
  assign ref_pos = foc_pkg::REF_FIRST_POS + {2'h0, ref_sel};

  assign is_ref = (r.samp_pos == ref_pos) || (r.samp_pos == ref_pos + 4'h1);

  assign coder_en = ~r.reg_power[foc_pkg::SLEEP_BIT] & r.reg_clamp[foc_pkg::SRST_BIT];

  always_comb begin
    logic [2:0] addr;
    logic pol;
    logic [4:0] lvl;
    addr = r.shift[2:0];
    pol = r.reg_clamp[foc_pkg::POL_BIT];
    lvl = r.reg_clamp[foc_pkg::CLAMP_LSB +: foc_pkg::CLAMP_W];
    n = r;
    n.leadin = 1'b0;

    // Two-stage synchronisers, third stage for edge detection
    n.sck_s = {r.sck_s[1:0], serial_clk};
    n.cs_s = {r.cs_s[1:0], serial_cs_n};
    n.sd_s = {r.sd_s[0], serial_write_line};
    n.sp_s = {r.sp_s[1:0], sample_pulse_input};
    n.sb_s = {r.sb_s[1:0], sample_blank_input};
    n.pb_s = {r.pb_s[1:0], pre_blank_input};
    n.ob_s = {r.ob_s[1:0], optical_black_pulse};

    if (cs_start) begin
      n.nbits = '0;
    end

    if (!r.cs_s[1] && sck_rise) begin
      // Extra clocks mark the word as bad rather than wrapping
      if (r.nbits != foc_pkg::WORD_OVER) begin
        n.nbits = r.nbits + 5'h01;
      end
      n.shift = {r.sd_s[1], r.shift[15:1]};
    end

    if (cs_end && (r.nbits == foc_pkg::WORD_BITS)) begin
      case (addr)
        foc_pkg::ADDR_GAIN: begin
          n.reg_gain = r.shift;
          n.leadin = step_of_one(new_gain, old_gain) & coder_en;
        end
        foc_pkg::ADDR_POWER: begin
          n.reg_power = r.shift;
        end
        foc_pkg::ADDR_CLAMP: begin
          n.reg_clamp = r.shift;
        end
        foc_pkg::ADDR_OUTPUT: begin
          n.reg_output = r.shift;
        end
        default: begin
          n.reg_gain = r.reg_gain;
        end
      endcase
    end
    if (cs_end) begin
      n.nbits = '0;
    end

    n.sp_o = r.sp_s[1] ^ ~pol;
    n.sb_o = r.sb_s[1] ^ ~pol;
    n.pb_o = r.pb_s[1] ^ ~pol;

    n.clamp_code = {4'h0, lvl, 1'b0} + foc_pkg::CLAMP_OFFSET;

    // Bias off only in direct mode
    n.cbias = r.reg_output[foc_pkg::CBIAS_BIT] & r.reg_gain[foc_pkg::PATH_BIT];

    // Sample positions count from the black pulse; saturate so late samples never alias
    if (obp_rise) begin
      n.samp_pos = '0;
    end else if (code_valid && (r.samp_pos != 4'hF)) begin
      n.samp_pos = r.samp_pos + 4'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
      // Serial clock idles high; a low reset value would fake an edge
      r.sck_s <= 3'h7;
      r.cs_s <= 3'h7;
      r.reg_gain <= foc_pkg::RST_GAIN;
      r.reg_power <= foc_pkg::RST_POWER;
      r.reg_clamp <= foc_pkg::RST_CLAMP;
      r.reg_output <= foc_pkg::RST_OUTPUT;
    end else begin
      r <= n;
    end
  end

  // Samples arrive on the system clock from the converter, so no crossing here
  foc_coder #(
    .CW(CW)
  ) u_coder (
    .clock(clock),
    .rst(rst),
    .enable(coder_en),
    .fmt(r.reg_output[foc_pkg::FMT_LSB +: foc_pkg::FMT_W]),
    .is_ref(is_ref),
    .code_valid(code_valid),
    .code_in(code_in),
    .code_out(code_out),
    .code_out_valid(code_out_valid),
    .code_out_ref(code_out_ref)
  );

  assign pga_gain_code = r.reg_gain[foc_pkg::GAIN_LSB +: foc_pkg::GAIN_W];
  assign input_path_select = r.reg_gain[foc_pkg::PATH_BIT];
  assign full_power_down = r.reg_power[foc_pkg::SLEEP_BIT];
  assign reference_only_hold = r.reg_power[foc_pkg::HOLD_BIT];
  assign sha_filter_select = r.reg_power[foc_pkg::SHA_LSB +: foc_pkg::SHA_W];
  assign black_sample_tc_select = r.reg_power[foc_pkg::TC_LSB +: foc_pkg::TC_W];
  assign clamp_target_code = r.clamp_code;
  assign fast_leadin_stop_select = r.reg_clamp[foc_pkg::STOP_LSB +: foc_pkg::LEADIN_W];
  assign fast_leadin_gain_mult = r.reg_clamp[foc_pkg::MULT_LSB +: foc_pkg::LEADIN_W];
  assign fast_leadin_start = r.leadin;
  assign speed_grade_select = r.reg_clamp[foc_pkg::SPEED_BIT];
  assign sample_pulse_out = r.sp_o;
  assign sample_blank_out = r.sb_o;
  assign pre_blank_out = r.pb_o;
  assign soft_reset_active = ~r.reg_clamp[foc_pkg::SRST_BIT];
  assign centre_bias_off = r.cbias;
  assign clamp_multi_line_average = r.reg_output[foc_pkg::AVG_BIT];
  assign converter_clock_edge = r.reg_output[foc_pkg::EDGE_BIT];

endmodule : foc_frontend_cfg

//--- test/foc_host_model.sv
// Purpose: Host side of the three-wire register write port
// Assumes: Serial period of eight system clocks (200 ns)
// Notes: Serial clock rests high between words; idle data line keeps toggling
`timescale 1ns/1ps
module foc_host_model (
  input wire logic clock,
  output logic serial_clk,
  output logic serial_cs_n,
  output logic serial_write_line
);
  initial begin
    serial_clk = 1'b1;
    serial_cs_n = 1'b1;
    serial_write_line = 1'b0;
  end
  // Unselected line never shows a stale bit the device could misread
  always @(posedge clock) begin
    if (serial_cs_n) begin
      serial_write_line <= ~serial_write_line;
    end
  end
  task automatic send(input logic [15:0] word, input int nbits);
    @(posedge clock) serial_cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clock) serial_write_line <= word[i % 16];
      serial_clk <= 1'b0;
      repeat (4) @(posedge clock);
      serial_clk <= 1'b1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock) serial_cs_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : send
endmodule : foc_host_model

//--- test/foc_frontend_cfg_assertions.sv
// Purpose: Port-level checks of the configuration block
// Assumes: Registers settle within five clocks of chip select rising
// Notes: Four checks wait nine clocks after reset for synchronisers
`timescale 1ns/1ps
module foc_frontend_cfg_assertions #(
  parameter int CW = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_cs_n,
  input wire logic sample_pulse_input,
  input wire logic sample_blank_input,
  input wire logic code_valid,
  input wire logic [7:0] pga_gain_code,
  input wire logic input_path_select,
  input wire logic full_power_down,
  input wire logic [9:0] clamp_target_code,
  input wire logic fast_leadin_start,
  input wire logic sample_pulse_out,
  input wire logic sample_blank_out,
  input wire logic soft_reset_active,
  input wire logic centre_bias_off,
  input wire logic [CW-1:0] code_out,
  input wire logic code_out_valid
);
  logic [3:0] up_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      up_r <= 4'h0;
    end else if (up_r != 4'hF) begin
      up_r <= up_r + 4'h1;
    end
  end
  wire logic ready = up_r > 4'h8;
  wire logic off = full_power_down | soft_reset_active;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_cs_quiet;
    $stable(serial_cs_n) [*8];
  endsequence
  sequence s_pins_still;
    $stable(sample_pulse_input ^ sample_blank_input) [*5];
  endsequence
  property p_clamp_law;
    ready |-> !clamp_target_code[0] && clamp_target_code >= 10'h00E && clamp_target_code <= 10'h04C;
  endproperty
  property p_regs_hold;
    s_cs_quiet |-> $stable({pga_gain_code, input_path_select, full_power_down, clamp_target_code, centre_bias_off});
  endproperty
  property p_timing_follow;
    s_pins_still |-> !ready || (sample_pulse_out ^ sample_blank_out) == (sample_pulse_input ^ sample_blank_input);
  endproperty
  property p_valid_cause;
    code_out_valid |-> $past(code_valid);
  endproperty
  property p_valid_follow;
    ready && code_valid && !off |=> code_out_valid;
  endproperty
  property p_sleep_mute;
    off [*2] |-> !code_out_valid;
  endproperty
  property p_code_hold;
    ready && !code_out_valid && !off |-> $stable(code_out);
  endproperty
  property p_bias_path;
    centre_bias_off |-> $past(input_path_select);
  endproperty
  property p_leadin_step;
    fast_leadin_start |-> 8'(pga_gain_code - $past(pga_gain_code, 2)) inside {8'h01, 8'hFF};
  endproperty
  property p_leadin_pulse;
    fast_leadin_start |=> !fast_leadin_start;
  endproperty
  a_clamp_law: assert property (p_clamp_law) else $error("clamp target off its ladder");
  a_regs_hold: assert property (p_regs_hold) else $error("register moved without a write");
  a_timing_follow: assert property (p_timing_follow) else $error("timing outputs disagree");
  a_valid_cause: assert property (p_valid_cause) else $error("output valid without input");
  a_valid_follow: assert property (p_valid_follow) else $error("code lost");
  a_sleep_mute: assert property (p_sleep_mute) else $error("code out while stopped");
  a_code_hold: assert property (p_code_hold) else $error("code changed without valid");
  a_bias_path: assert property (p_bias_path) else $error("bias off on wrong path");
  a_leadin_step: assert property (p_leadin_step) else $error("lead-in without unit step");
  a_leadin_pulse: assert property (p_leadin_pulse) else $error("lead-in pulse too long");
endmodule : foc_frontend_cfg_assertions
bind foc_frontend_cfg foc_frontend_cfg_assertions #(.CW(CW)) i_foc_frontend_cfg_assertions (.*);

//--- test/tb.sv
// Purpose: Self-checking bench of the configuration block
// Assumes: Gray of the difference in differential Gray mode
// Notes: Fixed seed; corner writes mixed with random ones
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic serial_clk, serial_cs_n, serial_write_line;
  logic sample_pulse_input = 1'b0, sample_blank_input = 1'b0, pre_blank_input = 1'b0;
  logic optical_black_pulse = 1'b0, code_valid = 1'b0;
  logic [9:0] code_in = 10'h000, code_out, clamp_target_code, pv = 10'h000;
  logic [7:0] pga_gain_code;
  logic input_path_select, full_power_down, reference_only_hold, fast_leadin_start, speed_grade_select;
  logic sample_pulse_out, sample_blank_out, pre_blank_out, soft_reset_active, centre_bias_off;
  logic clamp_multi_line_average, converter_clock_edge, code_out_valid, code_out_ref;
  logic [1:0] sha_filter_select, fast_leadin_stop_select, fast_leadin_gain_mult;
  logic [3:0] black_sample_tc_select;
  logic [15:0] rg [4];
  int failures = 0, cmp_count = 0, cyc = 0;
  int lead_cnt = 0, lead_base = 0;
  wire logic [63:0] seen_regs = {28'h0, pga_gain_code, input_path_select, full_power_down, reference_only_hold,
    sha_filter_select, black_sample_tc_select, clamp_target_code, fast_leadin_stop_select, fast_leadin_gain_mult,
    speed_grade_select, soft_reset_active, centre_bias_off, clamp_multi_line_average, converter_clock_edge};
  foc_frontend_cfg i_foc_frontend_cfg (.*);
  foc_host_model i_foc_host_model (.clock(clock), .serial_clk(serial_clk), .serial_cs_n(serial_cs_n),
    .serial_write_line(serial_write_line));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (fast_leadin_start !== 1'b0) lead_cnt++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [63:0] want();
    return {28'h0, rg[0][12:5], rg[0][15], rg[1][3], rg[1][4], rg[1][9:8], rg[1][13:10],
      {rg[2][7:3], 1'b0} + 10'h00E, rg[2][9:8], rg[2][11:10], rg[2][12], ~rg[2][15],
      rg[3][3] & rg[0][15], rg[3][6], rg[3][9]};
  endfunction : want
  function automatic logic [9:0] enc(input logic [1:0] f, input logic [9:0] c, input logic [9:0] p, input logic r);
    logic [9:0] v;
    v = (f[1] && !r) ? c - p : c;
    return f[0] ? v ^ (v >> 1) : v;
  endfunction : enc
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input int n);
    logic [2:0] v;
    i_foc_host_model.send({d[15:3], a}, n);
    if (n == 16 && a < 3'h4) rg[a] = {d[15:3], a};
    check(seen_regs, want());
    v = 3'($urandom);
    sample_pulse_input <= v[2];
    sample_blank_input <= v[1];
    pre_blank_input <= v[0];
    repeat (6) @(posedge clock);
    check({sample_pulse_out, sample_blank_out, pre_blank_out}, v ^ {3{~rg[2][13]}});
  endtask : wr
  task automatic burst(input logic [1:0] f, input logic [1:0] s);
    logic [9:0] c;
    logic r;
    wr(3'h3, {6'h00, 1'($urandom), s, 1'($urandom), f, 1'($urandom), 3'h0}, 16);
    @(posedge clock) optical_black_pulse <= 1'b1;
    repeat (4) @(posedge clock);
    optical_black_pulse <= 1'b0;
    repeat (4) @(posedge clock);
    for (int k = 0; k < 9; k++) begin
      c = (k == 5) ? pv : 10'($urandom);
      r = k == 3 + s || k == 4 + s;
      code_valid <= 1'b1;
      code_in <= c;
      @(posedge clock) code_valid <= 1'b0;
      #1;
      check(code_out_valid, 1'b1);
      check({code_out_ref, code_out}, {r, enc(f, c, pv, r)});
      pv = c;
      @(posedge clock);
    end
  endtask : burst
  initial begin
    logic [15:0] d;
    void'($urandom(32'h0e90));
    rg = '{foc_pkg::RST_GAIN, foc_pkg::RST_POWER, foc_pkg::RST_CLAMP, foc_pkg::RST_OUTPUT};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    check(seen_regs, want());
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom);
      if (i % 4 == 1) d[7:5] = 3'h0;
      if (i % 4 == 3) d[4] = 1'b0;
      wr(3'(i % 4), d, 16);
    end
    wr(3'h0, ~rg[0], 15);
    wr(3'h1, 16'hFFFF, 17);
    wr(3'h5, 16'hFFFF, 16);
    wr(3'h1, 16'h0000, 16);
    wr(3'h2, 16'h8000 | 16'($urandom), 16);
    lead_base = lead_cnt;
    wr(3'h0, {rg[0][15:13], rg[0][12:5] + 8'h01, 5'h00}, 16);
    check(64'(lead_cnt - lead_base), 64'h1);
    lead_base = lead_cnt;
    wr(3'h0, {rg[0][15:13], rg[0][12:5] + 8'h02, 5'h00}, 16);
    check(64'(lead_cnt - lead_base), 64'h0);
    for (int j = 0; j < 4; j++) burst(2'(j), 2'(j + 1));
    wr(3'h1, 16'h0008, 16);
    code_valid <= 1'b1;
    @(posedge clock) code_valid <= 1'b0;
    #1;
    check(code_out_valid, 1'b0);
    pv = 10'h000;
    wr(3'h1, 16'h0000, 16);
    burst(2'h2, 2'h0);
    complete_run();
  end
endmodule : tb
